/* File: aec_pkg.sv */
// Package for the event counter block: register map, field layout, reset values.
// Assumes a 32-bit AXI4-Lite register bus with byte addresses.
package aec_pkg;
    localparam logic [3:0] AEC_OFF_CTL = 4'h0;
    localparam logic [3:0] AEC_OFF_HIGH = 4'h4;
    localparam logic [3:0] AEC_OFF_LOW = 4'h8;
    localparam logic [3:0] AEC_OFF_CKSTP = 4'hc;
    localparam logic [3:0] AEC_OFF_IRQ_STAT = 4'h0;
    localparam logic [3:0] AEC_OFF_IRQ_MASK = 4'h0;
    localparam logic [7:0] AEC_ADDR_IRQ_STAT = 8'h10;
    localparam logic [7:0] AEC_ADDR_IRQ_MASK = 8'h14;
    localparam int AEC_BIT_OVH = 7;
    localparam int AEC_BIT_OVL = 6;
    localparam int AEC_BIT_SPLIT = 4;
    localparam int AEC_BIT_COUNT_ENABLE_HIGH = 3;
    localparam int AEC_BIT_COUNT_ENABLE_LOW = 2;
    localparam int AEC_BIT_COUNTER_RESET_CTL_HIGH = 1;
    localparam int AEC_BIT_COUNTER_RESET_CTL_LOW = 0;
    localparam int AEC_BIT_STBY = 3;
    localparam logic [7:0] AEC_CTL_RST = 8'h00;
    localparam logic [7:0] AEC_CNT_RST = 8'h00;
    localparam logic [7:0] AEC_CKSTP_RST = 8'hff;
    localparam logic [7:0] AEC_CNT_FULL = 8'hff;
    localparam logic [1:0] AEC_RESP_OKAY = 2'b00;
    localparam logic [1:0] AEC_RESP_SLVERR = 2'b10;

    typedef enum logic [1:0] {AEC_PM_RUN, AEC_PM_HOLD_FLAGS} aec_pmode_t;

    typedef struct packed {
        logic [1:0] s1;
        logic [1:0] s2;
        logic [1:0] prev;
    } aec_sync_t;

    typedef struct packed {
        aec_sync_t sy;
        logic [7:0] ctl;
        logic [7:0] ckstp;
        logic [7:0] cnt_h;
        logic [7:0] cnt_l;
        logic [1:0] rd_seen;
        logic irq_flag;
        logic irq_en;
        logic aw_got;
        logic w_got;
        logic [7:0] aw_addr;
        logic [31:0] w_data;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } aec_state_t;
endpackage : aec_pkg

/* File: aec_counter.sv */
// Event counter block: two 8-bit counters on two event pins, chained or split.
// Assumes event pins are asynchronous and much slower than core_clk; AXI4-Lite master.
// Overview of operation
// - High counter: 8-bit read-only, clocked by high pin or low overflow.
// - Software can clear the high counter; reset zeroes it.
// - Low counter: 8-bit read-only, always clocked by the low pin.
// - Software can clear the low counter; reset zeroes it.
// - Standby control bit 3 of clock stop register; zero means standby.
// - Split select zero chains into 16 bits; this holds after reset.
// - Chained wrap from full scale to zero sets high overflow flag.
// - Each overflow that sets an overflow flag also sets the request flag; enable gates the interrupt.
// - Split select one runs the two counters independently.
// - Split mode high wrap sets high overflow flag.
// - Split mode low wrap sets low overflow flag.
// - Watch mode counts but leaves overflow flags alone; standby stops both counters.
// - Split select is bit 4 of the control and status register.
// - Overflow flags set by hardware; cleared by read-one then write-zero.
// - Count enables bits 3 and 2 gate events to high and low.
// - Reset controls bits 1 and 0 hold counters reset while zero.
module aec_counter (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic event_pin_high,
    input wire logic event_pin_low,
    input wire aec_pkg::aec_pmode_t power_mode,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic irq
);
    aec_pkg::aec_state_t st_r;
    aec_pkg::aec_state_t st_nxt;

    function automatic logic [7:0] inc8(input logic [7:0] v);
        inc8 = v + 8'h01;
    endfunction : inc8

    logic [1:0] rise;
    logic run;
    logic split;
    logic tick_h;
    logic tick_l;
    logic wrap_h;
    logic wrap_l;
    logic flags_live;
    logic do_wr;
    logic do_rd;
    logic [31:0] rd_word;
    logic rd_ok;
    logic wr_ok;
    logic [7:0] wb;

    assign rise = st_r.sy.s2 & ~st_r.sy.prev;
    assign run = st_r.ckstp[aec_pkg::AEC_BIT_STBY];
    assign split = st_r.ctl[aec_pkg::AEC_BIT_SPLIT];
    assign flags_live = (power_mode == aec_pkg::AEC_PM_RUN);
    assign tick_l = run && rise[0] && st_r.ctl[aec_pkg::AEC_BIT_COUNT_ENABLE_LOW]
        && st_r.ctl[aec_pkg::AEC_BIT_COUNTER_RESET_CTL_LOW];
    assign wrap_l = tick_l && (st_r.cnt_l == aec_pkg::AEC_CNT_FULL);
    assign tick_h = run && st_r.ctl[aec_pkg::AEC_BIT_COUNT_ENABLE_HIGH] && st_r.ctl[aec_pkg::AEC_BIT_COUNTER_RESET_CTL_HIGH]
        && (split ? rise[1] : wrap_l);
    assign wrap_h = tick_h && (st_r.cnt_h == aec_pkg::AEC_CNT_FULL);

    assign s_axi_awready = !st_r.aw_got && !st_r.bvalid;
    assign s_axi_wready = !st_r.w_got && !st_r.bvalid;
    assign s_axi_arready = !st_r.rvalid;
    assign s_axi_bvalid = st_r.bvalid;
    assign s_axi_bresp = st_r.bresp;
    assign s_axi_rvalid = st_r.rvalid;
    assign s_axi_rdata = st_r.rdata;
    assign s_axi_rresp = st_r.rresp;
    assign irq = st_r.irq_flag && st_r.irq_en;

    always_comb
    begin
        rd_word = 32'h0000_0000;
        rd_ok = 1'b1;
        case (s_axi_araddr)
            {4'h0, aec_pkg::AEC_OFF_CTL}: rd_word = {24'h000000, st_r.ctl};
            {4'h0, aec_pkg::AEC_OFF_HIGH}: rd_word = {24'h000000, st_r.cnt_h};
            {4'h0, aec_pkg::AEC_OFF_LOW}: rd_word = {24'h000000, st_r.cnt_l};
            {4'h0, aec_pkg::AEC_OFF_CKSTP}: rd_word = {24'h000000, st_r.ckstp};
            aec_pkg::AEC_ADDR_IRQ_STAT: rd_word = {31'h0000_0000, st_r.irq_flag};
            aec_pkg::AEC_ADDR_IRQ_MASK: rd_word = {31'h0000_0000, st_r.irq_en};
            default: rd_ok = 1'b0;
        endcase
    end

    always_comb
    begin
        st_nxt = st_r;
        wb = st_r.w_data[7:0];
        wr_ok = 1'b1;
        do_wr = 1'b0;
        do_rd = 1'b0;
        st_nxt.sy.s1 = {event_pin_high, event_pin_low};
        st_nxt.sy.s2 = st_r.sy.s1;
        st_nxt.sy.prev = st_r.sy.s2;
        if (s_axi_awvalid && s_axi_awready)
        begin
            st_nxt.aw_got = 1'b1;
            st_nxt.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            st_nxt.w_got = 1'b1;
            st_nxt.w_data = s_axi_wdata;
            // Bit 8 carries no field, so it records lane 0 being off
            st_nxt.w_data[8] = !s_axi_wstrb[0];
        end
        if (st_r.bvalid && s_axi_bready)
            st_nxt.bvalid = 1'b0;
        if (st_r.rvalid && s_axi_rready)
            st_nxt.rvalid = 1'b0;
        if (st_r.aw_got && st_r.w_got && !st_r.bvalid)
        begin
            do_wr = 1'b1;
            st_nxt.aw_got = 1'b0;
            st_nxt.w_got = 1'b0;
            st_nxt.bvalid = 1'b1;
        end
        // Lane 0 off: answer the write but change nothing
        if (st_r.w_data[8])
            do_wr = 1'b0;
        if (st_r.aw_got && st_r.w_got && !st_r.bvalid)
        begin
            case (st_r.aw_addr)
                {4'h0, aec_pkg::AEC_OFF_CTL}:
                begin
                    if (do_wr)
                    begin
                        st_nxt.ctl[5:0] = wb[5:0];
                        if (!wb[aec_pkg::AEC_BIT_OVH] && st_r.rd_seen[1])
                            st_nxt.ctl[aec_pkg::AEC_BIT_OVH] = 1'b0;
                        if (!wb[aec_pkg::AEC_BIT_OVL] && st_r.rd_seen[0])
                            st_nxt.ctl[aec_pkg::AEC_BIT_OVL] = 1'b0;
                        st_nxt.rd_seen = 2'b00;
                    end
                end
                {4'h0, aec_pkg::AEC_OFF_HIGH}: wr_ok = 1'b1;
                {4'h0, aec_pkg::AEC_OFF_LOW}: wr_ok = 1'b1;
                {4'h0, aec_pkg::AEC_OFF_CKSTP}:
                    if (do_wr)
                        st_nxt.ckstp = {4'hf, wb[3:0]};
                aec_pkg::AEC_ADDR_IRQ_STAT:
                    if (do_wr && wb[0])
                        st_nxt.irq_flag = 1'b0;
                aec_pkg::AEC_ADDR_IRQ_MASK:
                    if (do_wr)
                        st_nxt.irq_en = wb[0];
                default: wr_ok = 1'b0;
            endcase
            st_nxt.bresp = wr_ok ? aec_pkg::AEC_RESP_OKAY : aec_pkg::AEC_RESP_SLVERR;
        end
        if (s_axi_arvalid && s_axi_arready)
        begin
            do_rd = 1'b1;
            st_nxt.rvalid = 1'b1;
            st_nxt.rdata = rd_word;
            st_nxt.rresp = rd_ok ? aec_pkg::AEC_RESP_OKAY : aec_pkg::AEC_RESP_SLVERR;
            if (s_axi_araddr == {4'h0, aec_pkg::AEC_OFF_CTL})
                st_nxt.rd_seen = st_r.rd_seen
                    | {st_r.ctl[aec_pkg::AEC_BIT_OVH], st_r.ctl[aec_pkg::AEC_BIT_OVL]};
        end
        // Counting after register writes so hardware events win
        if (tick_l)
            st_nxt.cnt_l = inc8(st_r.cnt_l);
        if (tick_h)
            st_nxt.cnt_h = inc8(st_r.cnt_h);
        if (!st_r.ctl[aec_pkg::AEC_BIT_COUNTER_RESET_CTL_LOW])
            st_nxt.cnt_l = aec_pkg::AEC_CNT_RST;
        if (!st_r.ctl[aec_pkg::AEC_BIT_COUNTER_RESET_CTL_HIGH])
            st_nxt.cnt_h = aec_pkg::AEC_CNT_RST;
        if (flags_live)
        begin
            if (wrap_h)
                st_nxt.ctl[aec_pkg::AEC_BIT_OVH] = 1'b1;
            if (wrap_l && split)
                st_nxt.ctl[aec_pkg::AEC_BIT_OVL] = 1'b1;
            if (wrap_h || (wrap_l && split))
                st_nxt.irq_flag = 1'b1;
        end
    end

    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            st_r <= '0;
            st_r.ctl <= aec_pkg::AEC_CTL_RST;
            st_r.ckstp <= aec_pkg::AEC_CKSTP_RST;
            st_r.cnt_h <= aec_pkg::AEC_CNT_RST;
            st_r.cnt_l <= aec_pkg::AEC_CNT_RST;
        end
        else
            st_r <= st_nxt;
    end

    sequence low_wrap_s;
        wrap_l && !split && flags_live;
    endsequence

    sequence high_wrap_s;
        wrap_h && flags_live;
    endsequence

    // Write in its commit cycle with byte lane 0 enabled
    sequence commit_s;
        st_r.aw_got && st_r.w_got && !st_r.bvalid && !st_r.w_data[8];
    endsequence

    // Committing write aimed at the control and status register
    sequence ctl_commit_s;
        commit_s ##0 (st_r.aw_addr == {4'h0, aec_pkg::AEC_OFF_CTL});
    endsequence

    // Counting and wrap
    chain_ovf_a: assert property (@(posedge core_clk) disable iff (reset)
        high_wrap_s ##0 !split
        |=> st_r.ctl[7] && st_r.cnt_h == 8'h00 && st_r.cnt_l == 8'h00)
        else $error("chained wrap did not set high flag");

    chain_low_a: assert property (@(posedge core_clk) disable iff (reset)
        low_wrap_s |=> !$rose(st_r.ctl[6]))
        else $error("chained low wrap set low flag");

    chain_carry_a: assert property (@(posedge core_clk) disable iff (reset)
        !split && tick_l && !wrap_l && st_r.ctl[1]
        |=> $stable(st_r.cnt_h))
        else $error("high counter moved without low carry");

    split_low_a: assert property (@(posedge core_clk) disable iff (reset)
        wrap_l && split && flags_live |=> st_r.ctl[6] && st_r.cnt_l == 8'h00)
        else $error("split low wrap wrong");

    split_high_a: assert property (@(posedge core_clk) disable iff (reset)
        high_wrap_s ##0 split |=> st_r.ctl[7] && st_r.irq_flag)
        else $error("split high wrap wrong");

    split_src_a: assert property (@(posedge core_clk) disable iff (reset)
        split && tick_l && !tick_h && st_r.ctl[1] |=> $stable(st_r.cnt_h))
        else $error("high counter followed low in split mode");

    low_step_a: assert property (@(posedge core_clk) disable iff (reset)
        tick_l && st_r.cnt_l != 8'hff
        |=> st_r.cnt_l == $past(st_r.cnt_l) + 8'h01)
        else $error("low counter did not step by one");

    high_step_a: assert property (@(posedge core_clk) disable iff (reset)
        tick_h && st_r.cnt_h != 8'hff
        |=> st_r.cnt_h == $past(st_r.cnt_h) + 8'h01)
        else $error("high counter did not step by one");

    standby_hold_a: assert property (@(posedge core_clk) disable iff (reset)
        !run && st_r.ctl[1:0] == 2'b11 |=> $stable(st_r.cnt_l) && $stable(st_r.cnt_h))
        else $error("counters moved in standby");

    low_reset_a: assert property (@(posedge core_clk) disable iff (reset)
        !st_r.ctl[0] |=> st_r.cnt_l == 8'h00)
        else $error("low counter not held reset");

    high_reset_a: assert property (@(posedge core_clk) disable iff (reset)
        !st_r.ctl[1] |=> st_r.cnt_h == 8'h00)
        else $error("high counter not held reset");

    hold_enable_a: assert property (@(posedge core_clk) disable iff (reset)
        !st_r.ctl[2] && st_r.ctl[0] |=> $stable(st_r.cnt_l))
        else $error("low counter moved while disabled");

    high_hold_a: assert property (@(posedge core_clk) disable iff (reset)
        !st_r.ctl[3] && st_r.ctl[1] |=> $stable(st_r.cnt_h))
        else $error("high counter moved while disabled");

    watch_flags_a: assert property (@(posedge core_clk) disable iff (reset)
        !flags_live && !do_wr ##1 1'b1 |-> !$rose(st_r.ctl[7]) && !$rose(st_r.ctl[6]))
        else $error("flags set in watch mode");

    // Flags and interrupt
    hw_high_a: assert property (@(posedge core_clk) disable iff (reset)
        !(wrap_h && flags_live) |=> !$rose(st_r.ctl[7]))
        else $error("high flag set without overflow");

    hw_low_a: assert property (@(posedge core_clk) disable iff (reset)
        !(wrap_l && split && flags_live) |=> !$rose(st_r.ctl[6]))
        else $error("low flag set without overflow");

    flag_sticky_a: assert property (@(posedge core_clk) disable iff (reset)
        ctl_commit_s ##0 (st_r.ctl[7] && !st_r.rd_seen[1])
        |=> st_r.ctl[7])
        else $error("high flag cleared without a read");

    irq_gate_a: assert property (@(posedge core_clk) disable iff (reset)
        (wrap_h || (wrap_l && split)) && flags_live && st_r.irq_en && !st_r.aw_got
        |=> irq)
        else $error("unmasked overflow raised no interrupt");

    irq_clear_a: assert property (@(posedge core_clk) disable iff (reset)
        commit_s ##0 (st_r.aw_addr == aec_pkg::AEC_ADDR_IRQ_STAT && st_r.w_data[0])
        ##0 !(wrap_h || (wrap_l && split)) |=> !st_r.irq_flag)
        else $error("request flag not cleared by write of one");

    // Register access
    ctl_write_a: assert property (@(posedge core_clk) disable iff (reset)
        ctl_commit_s
        |=> st_r.ctl[5:0] == $past(st_r.w_data[5:0]))
        else $error("control field write lost");

    ckstp_write_a: assert property (@(posedge core_clk) disable iff (reset)
        commit_s ##0 (st_r.aw_addr == {4'h0, aec_pkg::AEC_OFF_CKSTP})
        |=> st_r.ckstp == {4'hf, $past(st_r.w_data[3:0])})
        else $error("clock stop write lost");

    count_ro_a: assert property (@(posedge core_clk) disable iff (reset)
        commit_s ##0 (st_r.aw_addr == {4'h0, aec_pkg::AEC_OFF_HIGH})
        ##0 (!tick_h && st_r.ctl[1]) |=> $stable(st_r.cnt_h))
        else $error("high counter took a bus write");

    lane_off_a: assert property (@(posedge core_clk) disable iff (reset)
        st_r.aw_got && st_r.w_got && !st_r.bvalid && st_r.w_data[8]
        |=> $stable(st_r.ctl[5:0]) && $stable(st_r.ckstp) && $stable(st_r.irq_en))
        else $error("write with lane 0 off changed a register");

    wr_answer_a: assert property (@(posedge core_clk) disable iff (reset)
        st_r.aw_got && st_r.w_got && !st_r.bvalid
        |=> s_axi_bvalid && !s_axi_awready && !s_axi_wready)
        else $error("write response missing");

    rd_answer_a: assert property (@(posedge core_clk) disable iff (reset)
        do_rd |=> s_axi_rvalid && !s_axi_arready)
        else $error("read response missing");
endmodule : aec_counter

/* File: aec_event_src.sv */
// Event source standing in for one asynchronous event pin.
// Assumes a 200 ns event period; the pin rests low between bursts.
module aec_event_src (
    output logic event_pin
);
    timeunit 1ns;
    timeprecision 100ps;
    initial event_pin = 1'b0;
    // Burst of n full pulses, each wide enough for the synchroniser
    task automatic pulses(input int n);
        repeat (n)
        begin
            event_pin <= 1'b1;
            #100;
            event_pin <= 1'b0;
            #100;
        end
    endtask : pulses
endmodule : aec_event_src

/* File: testbench.sv */
// Testbench for the event counter: register bus master and two event sources.
// Assumes aec_pkg, aec_counter and aec_event_src are compiled first.
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    aec_pkg::aec_pmode_t power_mode = aec_pkg::AEC_PM_RUN;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic [3:0] wstrb = 4'hf;
    logic awready, wready, bvalid, arready, rvalid, irq, pin_h, pin_l;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    int n_fail = 0;
    int checks_done = 0;
    int cyc = 0;
    always #12.5 core_clk = ~core_clk;
    aec_event_src src_h (.event_pin(pin_h));
    aec_event_src src_l (.event_pin(pin_l));
    aec_counter dut (.core_clk(core_clk), .reset(reset), .event_pin_high(pin_h),
        .event_pin_low(pin_l), .power_mode(power_mode), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .irq(irq));
    task automatic results();
        if (n_fail == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : results
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Handshakes judged mid-cycle, where ready is settled for the coming edge
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic aw_p = 1'b1;
        logic w_p = 1'b1;
        logic ta, tw, tb;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        tb = 1'b0;
        while (!tb)
        begin
            @(negedge core_clk);
            ta = aw_p && awready;
            tw = w_p && wready;
            tb = !aw_p && !w_p && bvalid;
            if (tb)
                chk({30'h0, bresp}, {30'h0, aec_pkg::AEC_RESP_OKAY});
            @(posedge core_clk);
            if (ta)
                awvalid <= 1'b0;
            if (tw)
                wvalid <= 1'b0;
            if (tb)
                bready <= 1'b0;
            aw_p = aw_p && !ta;
            w_p = w_p && !tw;
        end
        // One idle edge before a following request
        @(posedge core_clk);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] exp,
        input logic [1:0] er);
        logic ar_p = 1'b1;
        logic ta, tr;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        tr = 1'b0;
        while (!tr)
        begin
            @(negedge core_clk);
            ta = ar_p && arready;
            tr = !ar_p && rvalid;
            if (tr)
            begin
                chk({30'h0, rresp}, {30'h0, er});
                if (er === aec_pkg::AEC_RESP_OKAY)
                    chk(rdata, exp);
            end
            @(posedge core_clk);
            if (ta)
                arvalid <= 1'b0;
            if (tr)
                rready <= 1'b0;
            ar_p = ar_p && !ta;
        end
        @(posedge core_clk);
    endtask : rd
    task automatic rk(input logic [7:0] a, input logic [31:0] exp);
        rd(a, exp, aec_pkg::AEC_RESP_OKAY);
    endtask : rk
    task automatic t_reset_vals();
        rk(8'h00, 32'h00);
        rk(8'h04, 32'h00);
        rk(8'h08, 32'h00);
        rk(8'h0c, 32'hff);
        rd(8'h18, 32'h0, aec_pkg::AEC_RESP_SLVERR);
        chk({31'h0, irq}, 32'h0);
    endtask : t_reset_vals
    task automatic t_chain();
        wr(8'h00, 32'h0f);
        src_l.pulses(256);
        rk(8'h08, 32'h00);
        rk(8'h04, 32'h01);
        rk(8'h00, 32'h0f);
        wr(8'h04, 32'h55);
        rk(8'h04, 32'h01);
    endtask : t_chain
    task automatic t_split();
        wr(8'h00, 32'h1f);
        src_h.pulses(254);
        rk(8'h04, 32'hff);
        src_h.pulses(1);
        rk(8'h04, 32'h00);
        rk(8'h08, 32'h00);
        wr(8'h00, 32'h1f);
        rk(8'h00, 32'h9f);
        rk(8'h10, 32'h01);
        chk({31'h0, irq}, 32'h0);
        wr(8'h14, 32'h01);
        rk(8'h14, 32'h01);
        chk({31'h0, irq}, 32'h1);
        wr(8'h10, 32'h01);
        chk({31'h0, irq}, 32'h0);
        src_l.pulses(256);
        rk(8'h00, 32'hdf);
        chk({31'h0, irq}, 32'h1);
        wr(8'h10, 32'h01);
        wr(8'h00, 32'h1f);
        rk(8'h00, 32'h1f);
    endtask : t_split
    task automatic t_gate_hold();
        wr(8'h00, 32'h1b);
        src_l.pulses(3);
        rk(8'h08, 32'h00);
        wr(8'h00, 32'h1f);
        src_l.pulses(3);
        rk(8'h08, 32'h03);
        power_mode <= aec_pkg::AEC_PM_HOLD_FLAGS;
        src_l.pulses(254);
        rk(8'h08, 32'h01);
        rk(8'h00, 32'h1f);
        rk(8'h10, 32'h00);
        power_mode <= aec_pkg::AEC_PM_RUN;
        wr(8'h0c, 32'hf7);
        rk(8'h0c, 32'hf7);
        src_l.pulses(2);
        rk(8'h08, 32'h01);
        wr(8'h0c, 32'hff);
        src_l.pulses(2);
        rk(8'h08, 32'h03);
        src_h.pulses(2);
        rk(8'h04, 32'h02);
        wr(8'h00, 32'h1c);
        rk(8'h08, 32'h00);
        rk(8'h04, 32'h00);
        wstrb <= 4'he;
        wr(8'h00, 32'h1f);
        wstrb <= 4'hf;
        rk(8'h00, 32'h1c);
    endtask : t_gate_hold
    // High counter preset to full scale, then a chained carry wraps both
    task automatic t_chain_wrap();
        src_h.pulses(255);
        rk(8'h04, 32'hff);
        wr(8'h00, 32'h0f);
        src_l.pulses(256);
        rk(8'h08, 32'h00);
        rk(8'h04, 32'h00);
        rk(8'h00, 32'h8f);
        chk({31'h0, irq}, 32'h1);
        wr(8'h10, 32'h01);
        chk({31'h0, irq}, 32'h0);
    endtask : t_chain_wrap
    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == 40000)
        begin
            n_fail++;
            results();
        end
    end
    initial
    begin
        repeat (4) @(posedge core_clk);
        reset <= 1'b0;
        @(posedge core_clk);
        t_reset_vals();
        t_chain();
        t_split();
        t_chain_wrap();
        t_gate_hold();
        results();
    end
endmodule : testbench
